// *** core/event_reg_set.sv ***
// Shared constants for the status summary block, and one event register set.
// Assumes all inputs are synchronous to i_sys_clk; i_srst is the power-on clear.
package ssr_pkg;
    localparam int unsigned REG_W       = 16;
    localparam int unsigned STB_W       = 8;
    localparam int unsigned SEL_W       = 4;
    localparam int unsigned ERRQ_DEPTH  = 10;
    localparam int unsigned OUTQ_DEPTH  = 4;
    // Status byte bit positions
    localparam int unsigned STB_MEAS    = 0;
    localparam int unsigned STB_UNUSED  = 1;
    localparam int unsigned STB_ERR     = 2;
    localparam int unsigned STB_QUES    = 3;
    localparam int unsigned STB_MSG     = 4;
    localparam int unsigned STB_STD     = 5;
    localparam int unsigned STB_RQS     = 6;
    localparam int unsigned STB_OPER    = 7;
    localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
    localparam logic [STB_W-1:0] STB_RESET = 8'h00;

    // Register selector for enable writes and queries
    typedef enum logic [SEL_W-1:0] {
        SEL_STD_EVENT  = 4'b0000,
        SEL_STD_ENABLE = 4'b0001,
        SEL_OPER_COND  = 4'b0010,
        SEL_OPER_EVENT = 4'b0011,
        SEL_OPER_ENABLE= 4'b0100,
        SEL_MEAS_COND  = 4'b0101,
        SEL_MEAS_EVENT = 4'b0110,
        SEL_MEAS_ENABLE= 4'b0111,
        SEL_QUES_COND  = 4'b1000,
        SEL_QUES_EVENT = 4'b1001,
        SEL_QUES_ENABLE= 4'b1010,
        SEL_STB        = 4'b1011,
        SEL_SRE        = 4'b1100
    } reg_sel_t;
endpackage : ssr_pkg

`timescale 1ns/10ps
module event_reg_set
    import ssr_pkg::*;
#(
    parameter int unsigned W = REG_W
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_srst,
    input  wire logic [W-1:0] i_cond,
    input  wire logic [W-1:0] i_event,
    input  wire logic         i_event_clr,
    input  wire logic         i_enable_wr,
    input  wire logic [W-1:0] i_enable_data,
    input  wire logic         i_enable_clr,
    output logic      [W-1:0] o_cond,
    output logic      [W-1:0] o_event,
    output logic      [W-1:0] o_enable,
    output logic              o_summary
);
    logic [W-1:0] cond_ff;
    logic [W-1:0] event_ff;
    logic [W-1:0] enable_ff;

    // Condition follows the live state, no latching
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            cond_ff <= W'(REG_RESET);
        end else begin
            cond_ff <= i_cond;
        end
    end

    // Sticky event bits; a new event wins over a same-cycle clear
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            event_ff <= W'(REG_RESET);
        end else begin
            event_ff <= (i_event_clr ? W'(REG_RESET) : event_ff) | i_event;
        end
    end

    // Enable is the only host-writable part; write wins over preset
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            enable_ff <= W'(REG_RESET);
        end else if (i_enable_wr) begin
            enable_ff <= i_enable_data;
        end else if (i_enable_clr) begin
            enable_ff <= W'(REG_RESET);
        end
    end

    assign o_cond    = cond_ff;
    assign o_event   = event_ff;
    assign o_enable  = enable_ff;
    assign o_summary = |(event_ff & enable_ff);
endmodule : event_reg_set

// *** core/status_summary_service_request.sv ***
// Status byte, service request enable and queue summaries of the status structure.
// Assumes one synchronous clock, a command decoder that issues one-cycle strobes,
// and firmware that renders query values as decimal text.
`timescale 1ns/10ps
module status_summary_service_request
    import ssr_pkg::*;
#(
    parameter int unsigned ERR_DEPTH = ERRQ_DEPTH,
    parameter int unsigned OUT_DEPTH = OUTQ_DEPTH
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_srst,
    // Live conditions and one-cycle event pulses of the four sets
    input  wire logic [REG_W-1:0] i_std_cond,
    input  wire logic [REG_W-1:0] i_std_event,
    input  wire logic [REG_W-1:0] i_oper_cond,
    input  wire logic [REG_W-1:0] i_oper_event,
    input  wire logic [REG_W-1:0] i_meas_cond,
    input  wire logic [REG_W-1:0] i_meas_event,
    input  wire logic [REG_W-1:0] i_ques_cond,
    input  wire logic [REG_W-1:0] i_ques_event,
    // Queue traffic
    input  wire logic             i_err_push,
    input  wire logic             i_err_pop,
    input  wire logic             i_out_push,
    input  wire logic             i_out_pop,
    // Command strobes
    input  wire logic             i_clear_status,
    input  wire logic             i_status_preset,
    input  wire logic             i_queue_clear,
    input  wire logic             i_system_clear,
    input  wire logic             i_system_preset,
    input  wire logic             i_reset_cmd,
    input  wire logic             i_serial_poll,
    // Enable write and register query
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    input  wire logic [SEL_W-1:0] i_sel,
    input  wire logic [REG_W-1:0] i_wr_data,
    output logic      [REG_W-1:0] o_rd_data,
    output logic                  o_rd_valid,
    output logic      [STB_W-1:0] o_poll_byte,
    output logic                  o_poll_valid,
    output logic      [STB_W-1:0] o_status_byte,
    output logic                  o_service_request,
    output logic                  o_err_full,
    output logic                  o_out_full
);
    localparam int unsigned ERR_CW = $clog2(ERR_DEPTH + 1);
    localparam int unsigned OUT_CW = $clog2(OUT_DEPTH + 1);
    localparam logic [ERR_CW-1:0] ERR_ZERO = '0;
    localparam logic [OUT_CW-1:0] OUT_ZERO = '0;
    localparam logic [ERR_CW-1:0] ERR_ONE  = ERR_CW'(1);
    localparam logic [OUT_CW-1:0] OUT_ONE  = OUT_CW'(1);
    localparam logic [ERR_CW-1:0] ERR_MAX  = ERR_CW'(ERR_DEPTH);
    localparam logic [OUT_CW-1:0] OUT_MAX  = OUT_CW'(OUT_DEPTH);

    reg_sel_t           sel;
    logic [REG_W-1:0]   std_cond, std_event, std_enable;
    logic [REG_W-1:0]   oper_cond, oper_event, oper_enable;
    logic [REG_W-1:0]   meas_cond, meas_event, meas_enable;
    logic [REG_W-1:0]   ques_cond, ques_event, ques_enable;
    logic               std_sum, oper_sum, meas_sum, ques_sum;
    logic [STB_W-1:0]   sre_ff;
    logic [ERR_CW-1:0]  err_count_ff;
    logic [OUT_CW-1:0]  out_count_ff;
    logic               rqs_ff;
    logic [STB_W-1:0]   summary_vec;
    logic [STB_W-1:0]   sre_masked;
    logic [STB_W-1:0]   enabled_sum;
    logic [STB_W-1:0]   enabled_sum_ff;
    logic               mss;
    logic               rise;
    logic               err_clear;
    logic [REG_W-1:0]   nxt_rd_data;
    logic [REG_W-1:0]   rd_data_ff;
    logic               rd_valid_ff;
    logic [STB_W-1:0]   poll_byte_ff;
    logic               poll_valid_ff;
    logic [STB_W-1:0]   status_byte_ff;
    logic               srq_ff;
    logic               err_full_ff;
    logic               out_full_ff;

    assign sel = reg_sel_t'(i_sel);

    ////////////////////////////////////////////////////////////////////////////
    // Four event register sets; system preset and reset command are not wired
    event_reg_set #(.W(REG_W)) u_std (
        .i_sys_clk     (i_sys_clk),
        .i_srst        (i_srst),
        .i_cond        (i_std_cond),
        .i_event       (i_std_event),
        .i_event_clr   (i_clear_status | (i_rd && sel == SEL_STD_EVENT)),
        .i_enable_wr   (i_wr && sel == SEL_STD_ENABLE),
        .i_enable_data (i_wr_data),
        .i_enable_clr  (1'b0),
        .o_cond        (std_cond),
        .o_event       (std_event),
        .o_enable      (std_enable),
        .o_summary     (std_sum)
    );

    event_reg_set #(.W(REG_W)) u_oper (
        .i_sys_clk     (i_sys_clk),
        .i_srst        (i_srst),
        .i_cond        (i_oper_cond),
        .i_event       (i_oper_event),
        .i_event_clr   (i_clear_status | (i_rd && sel == SEL_OPER_EVENT)),
        .i_enable_wr   (i_wr && sel == SEL_OPER_ENABLE),
        .i_enable_data (i_wr_data),
        .i_enable_clr  (i_status_preset),
        .o_cond        (oper_cond),
        .o_event       (oper_event),
        .o_enable      (oper_enable),
        .o_summary     (oper_sum)
    );

    event_reg_set #(.W(REG_W)) u_meas (
        .i_sys_clk     (i_sys_clk),
        .i_srst        (i_srst),
        .i_cond        (i_meas_cond),
        .i_event       (i_meas_event),
        .i_event_clr   (i_clear_status | (i_rd && sel == SEL_MEAS_EVENT)),
        .i_enable_wr   (i_wr && sel == SEL_MEAS_ENABLE),
        .i_enable_data (i_wr_data),
        .i_enable_clr  (i_status_preset),
        .o_cond        (meas_cond),
        .o_event       (meas_event),
        .o_enable      (meas_enable),
        .o_summary     (meas_sum)
    );

    event_reg_set #(.W(REG_W)) u_ques (
        .i_sys_clk     (i_sys_clk),
        .i_srst        (i_srst),
        .i_cond        (i_ques_cond),
        .i_event       (i_ques_event),
        .i_event_clr   (i_clear_status | (i_rd && sel == SEL_QUES_EVENT)),
        .i_enable_wr   (i_wr && sel == SEL_QUES_ENABLE),
        .i_enable_data (i_wr_data),
        .i_enable_clr  (i_status_preset),
        .o_cond        (ques_cond),
        .o_event       (ques_event),
        .o_enable      (ques_enable),
        .o_summary     (ques_sum)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Service request enable: power-up or write only
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            sre_ff <= STB_RESET;
        end else if (i_wr && sel == SEL_SRE) begin
            sre_ff <= i_wr_data[STB_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Queue occupancy; pushes into a full queue are dropped
    assign err_clear = i_clear_status | i_queue_clear | i_system_clear;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst || err_clear) begin
            err_count_ff <= ERR_ZERO;
        end else if (i_err_push && !i_err_pop && err_count_ff != ERR_MAX) begin
            err_count_ff <= err_count_ff + ERR_ONE;
        end else if (i_err_pop && !i_err_push && err_count_ff != ERR_ZERO) begin
            err_count_ff <= err_count_ff - ERR_ONE;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            out_count_ff <= OUT_ZERO;
        end else if (i_out_push && !i_out_pop && out_count_ff != OUT_MAX) begin
            out_count_ff <= out_count_ff + OUT_ONE;
        end else if (i_out_pop && !i_out_push && out_count_ff != OUT_ZERO) begin
            out_count_ff <= out_count_ff - OUT_ONE;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            err_full_ff <= 1'b0;
            out_full_ff <= 1'b0;
        end else begin
            err_full_ff <= (err_count_ff == ERR_MAX);
            out_full_ff <= (out_count_ff == OUT_MAX);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Summary vector, unlatched, and master summary
    always_comb begin
        summary_vec             = STB_RESET;
        summary_vec[STB_MEAS]   = meas_sum;
        summary_vec[STB_UNUSED] = 1'b0;
        summary_vec[STB_ERR]    = (err_count_ff != ERR_ZERO);
        summary_vec[STB_QUES]   = ques_sum;
        summary_vec[STB_MSG]    = (out_count_ff != OUT_ZERO);
        summary_vec[STB_STD]    = std_sum;
        summary_vec[STB_RQS]    = 1'b0;
        summary_vec[STB_OPER]   = oper_sum;
    end

    always_comb begin
        sre_masked          = sre_ff;
        sre_masked[STB_RQS] = 1'b0;
    end

    assign enabled_sum = summary_vec & sre_masked;
    assign mss         = |enabled_sum;
    assign rise        = |(enabled_sum & ~enabled_sum_ff);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            enabled_sum_ff <= STB_RESET;
        end else begin
            enabled_sum_ff <= enabled_sum;
        end
    end

    // Request service: set on a rising enabled summary, cleared by poll; set wins
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rqs_ff <= 1'b0;
        end else if (rise) begin
            rqs_ff <= 1'b1;
        end else if (i_serial_poll) begin
            rqs_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            srq_ff <= 1'b0;
        end else begin
            srq_ff <= rise | (rqs_ff & ~i_serial_poll);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status byte image: B6 shows master summary
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            status_byte_ff <= STB_RESET;
        end else begin
            status_byte_ff          <= summary_vec;
            status_byte_ff[STB_RQS] <= mss;
        end
    end

    // Serial poll answer: B6 shows request service
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            poll_byte_ff  <= STB_RESET;
            poll_valid_ff <= 1'b0;
        end else begin
            poll_valid_ff <= i_serial_poll;
            if (i_serial_poll) begin
                poll_byte_ff          <= summary_vec;
                poll_byte_ff[STB_RQS] <= rqs_ff | rise;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Query mux: binary pattern, rendered as decimal by firmware
    always_comb begin
        nxt_rd_data = REG_RESET;
        unique case (sel)
            SEL_STD_EVENT:   nxt_rd_data = std_event;
            SEL_STD_ENABLE:  nxt_rd_data = std_enable;
            SEL_OPER_COND:   nxt_rd_data = oper_cond;
            SEL_OPER_EVENT:  nxt_rd_data = oper_event;
            SEL_OPER_ENABLE: nxt_rd_data = oper_enable;
            SEL_MEAS_COND:   nxt_rd_data = meas_cond;
            SEL_MEAS_EVENT:  nxt_rd_data = meas_event;
            SEL_MEAS_ENABLE: nxt_rd_data = meas_enable;
            SEL_QUES_COND:   nxt_rd_data = ques_cond;
            SEL_QUES_EVENT:  nxt_rd_data = ques_event;
            SEL_QUES_ENABLE: nxt_rd_data = ques_enable;
            SEL_STB: begin
                nxt_rd_data                   = {{(REG_W-STB_W){1'b0}}, summary_vec};
                nxt_rd_data[STB_RQS]          = mss;
            end
            SEL_SRE:         nxt_rd_data = {{(REG_W-STB_W){1'b0}}, sre_ff};
            default:         nxt_rd_data = REG_RESET;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rd_data_ff  <= REG_RESET;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= i_rd;
            if (i_rd) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    // Standard condition is kept for completeness but has no query code
    logic std_cond_unused;
    assign std_cond_unused = |std_cond | i_system_preset | i_reset_cmd;

    assign o_rd_data         = rd_data_ff;
    assign o_rd_valid        = rd_valid_ff;
    assign o_poll_byte       = poll_byte_ff;
    assign o_poll_valid      = poll_valid_ff;
    assign o_status_byte     = status_byte_ff;
    assign o_service_request = srq_ff;
    assign o_err_full        = err_full_ff;
    assign o_out_full        = out_full_ff;
endmodule : status_summary_service_request

// *** verif/ssr_host.sv ***
// Host model: issues enable writes, register queries and serial polls.
// Assumes callers wait for each request task to return before the next.
`timescale 1ns/10ps
module ssr_host
    import ssr_pkg::*;
(
    input  wire logic             i_sys_clk,
    output logic                  o_wr,
    output logic                  o_rd,
    output logic                  o_poll,
    output logic      [SEL_W-1:0] o_sel,
    output logic      [REG_W-1:0] o_wr_data
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_poll = 1'b0;
        o_sel = 4'h0;
        o_wr_data = 16'h0000;
    end

    // One-cycle request; afterwards wr, rd and poll drop low while select and data show the inverse value
    task automatic put(input logic w, input logic r, input logic p, input logic [SEL_W-1:0] s,
                       input logic [REG_W-1:0] d);
        @(negedge i_sys_clk);
        o_wr = w;
        o_rd = r;
        o_poll = p;
        o_sel = s;
        o_wr_data = d;
        @(negedge i_sys_clk);
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_poll = 1'b0;
        o_sel = ~s;
        o_wr_data = ~d;
    endtask : put
endmodule : ssr_host

// *** verif/ssr_monitor.sv ***
// Checker for the status summary block, bound to its top-level ports.
// Assumes one clock and the synchronous reset as power-on clear.
`timescale 1ns/10ps
module ssr_monitor
    import ssr_pkg::*;
#(
    parameter int unsigned ERR_DEPTH = ERRQ_DEPTH,
    parameter int unsigned OUT_DEPTH = OUTQ_DEPTH
) (
    input wire logic             i_sys_clk,
    input wire logic             i_srst,
    input wire logic [REG_W-1:0] i_std_event,
    input wire logic [REG_W-1:0] i_oper_event,
    input wire logic [REG_W-1:0] i_meas_event,
    input wire logic [REG_W-1:0] i_ques_event,
    input wire logic             i_err_push,
    input wire logic             i_err_pop,
    input wire logic             i_out_push,
    input wire logic             i_out_pop,
    input wire logic             i_clear_status,
    input wire logic             i_queue_clear,
    input wire logic             i_system_clear,
    input wire logic             i_serial_poll,
    input wire logic             i_wr,
    input wire logic             i_rd,
    input wire logic [SEL_W-1:0] i_sel,
    input wire logic [REG_W-1:0] o_rd_data,
    input wire logic             o_rd_valid,
    input wire logic [STB_W-1:0] o_poll_byte,
    input wire logic             o_poll_valid,
    input wire logic [STB_W-1:0] o_status_byte,
    input wire logic             o_service_request
);
    wire logic err_clr = i_clear_status | i_queue_clear | i_system_clear;
    // Nothing that could raise a summary bit
    wire logic calm = ~|{i_std_event, i_oper_event, i_meas_event, i_ques_event, i_err_push, i_out_push, i_wr};
    wire logic oper_rd = i_rd && (i_sel == SEL_OPER_EVENT) && (i_oper_event == 16'h0000);

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    ////////////////////////////////////////////////////////////////////////////
    sequence s_err_in; (i_err_push && !i_err_pop && !err_clr) ##1 (!i_err_pop && !err_clr); endsequence
    sequence s_out_in; (i_out_push && !i_out_pop) ##1 !i_out_pop; endsequence
    sequence s_calm_poll; calm [*4] ##0 i_serial_poll; endsequence
    sequence s_double_read; oper_rd ##1 (i_oper_event == 16'h0000) ##1 oper_rd; endsequence

    property p_rd_valid; i_rd |=> o_rd_valid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("query answer missing");
    property p_poll_valid; i_serial_poll |=> o_poll_valid; endproperty
    a_poll_valid: assert property (p_poll_valid) else $error("poll answer missing");
    property p_poll_rqs;
        i_serial_poll |=> o_poll_byte[STB_RQS] == ($past(o_service_request) | o_service_request); endproperty
    a_poll_rqs: assert property (p_poll_rqs) else $error("poll byte bit six wrong");
    property p_calm_poll; s_calm_poll |=> !o_service_request; endproperty
    a_calm_poll: assert property (p_calm_poll) else $error("request survives poll");
    property p_reset_zero; $fell(i_srst) |-> (o_status_byte == 8'h00) && !o_service_request; endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("status not clear after reset");
    property p_err_avail; s_err_in |=> o_status_byte[STB_ERR]; endproperty
    a_err_avail: assert property (p_err_avail) else $error("error available missing");
    property p_msg_avail; s_out_in |=> o_status_byte[STB_MSG]; endproperty
    a_msg_avail: assert property (p_msg_avail) else $error("message available missing");
    property p_err_clear; err_clr |=> ##1 !o_status_byte[STB_ERR]; endproperty
    a_err_clear: assert property (p_err_clear) else $error("error queue not emptied");
    property p_byte_width; i_rd && (i_sel == SEL_SRE || i_sel == SEL_STB) |=> o_rd_data[15:8] == 8'h00; endproperty
    a_byte_width: assert property (p_byte_width) else $error("byte register wider than eight");
    property p_read_clears; s_double_read |=> o_rd_data == 16'h0000; endproperty
    a_read_clears: assert property (p_read_clears) else $error("event read did not clear");
    property p_unused_bit; !o_status_byte[STB_UNUSED] && !o_poll_byte[STB_UNUSED]; endproperty
    a_unused_bit: assert property (p_unused_bit) else $error("unused status bit set");
endmodule : ssr_monitor

bind status_summary_service_request ssr_monitor #(.ERR_DEPTH(ERR_DEPTH), .OUT_DEPTH(OUT_DEPTH)) u_mon (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_std_event(i_std_event), .i_oper_event(i_oper_event),
    .i_meas_event(i_meas_event), .i_ques_event(i_ques_event), .i_err_push(i_err_push), .i_err_pop(i_err_pop),
    .i_out_push(i_out_push), .i_out_pop(i_out_pop), .i_clear_status(i_clear_status),
    .i_queue_clear(i_queue_clear), .i_system_clear(i_system_clear), .i_serial_poll(i_serial_poll),
    .i_wr(i_wr), .i_rd(i_rd), .i_sel(i_sel), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_poll_byte(o_poll_byte), .o_poll_valid(o_poll_valid), .o_status_byte(o_status_byte),
    .o_service_request(o_service_request));

// *** verif/status_summary_service_request_test.sv ***
// Self-checking bench for the status summary block.
// Assumes ssr_pkg, the design, the host model and the checker compiled first.
`timescale 1ns/10ps
module status_summary_service_request_test;
    import ssr_pkg::*;
    logic             clk, srst, wr, rd, poll, rd_valid, poll_valid, srq, err_full, out_full;
    logic [9:0]       cmd;
    logic [SEL_W-1:0] sel;
    logic [REG_W-1:0] wr_data, rd_data, r;
    logic [REG_W-1:0] cond [4];
    logic [REG_W-1:0] evt [4];
    logic [STB_W-1:0] poll_byte, status_byte, b;
    logic [16:0]      exp_q [$];
    logic [16:0]      e;
    int               bad_count, checks, cyc, i, seed;
    reg_sel_t         ev_sel [4] = '{SEL_STD_EVENT, SEL_OPER_EVENT, SEL_MEAS_EVENT, SEL_QUES_EVENT};
    reg_sel_t         en_sel [4] = '{SEL_STD_ENABLE, SEL_OPER_ENABLE, SEL_MEAS_ENABLE, SEL_QUES_ENABLE};
    int               sb_bit [4] = '{STB_STD, STB_OPER, STB_MEAS, STB_QUES};

    status_summary_service_request #(.ERR_DEPTH(4), .OUT_DEPTH(OUTQ_DEPTH)) i_dut (
        .i_sys_clk(clk), .i_srst(srst), .i_std_cond(cond[0]), .i_std_event(evt[0]), .i_oper_cond(cond[1]),
        .i_oper_event(evt[1]), .i_meas_cond(cond[2]), .i_meas_event(evt[2]), .i_ques_cond(cond[3]),
        .i_ques_event(evt[3]), .i_err_push(cmd[6]), .i_err_pop(cmd[7]), .i_out_push(cmd[8]), .i_out_pop(cmd[9]),
        .i_clear_status(cmd[0]), .i_status_preset(cmd[1]), .i_queue_clear(cmd[2]), .i_system_clear(cmd[3]),
        .i_system_preset(cmd[4]), .i_reset_cmd(cmd[5]), .i_serial_poll(poll), .i_wr(wr), .i_rd(rd),
        .i_sel(sel), .i_wr_data(wr_data), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_poll_byte(poll_byte),
        .o_poll_valid(poll_valid), .o_status_byte(status_byte), .o_service_request(srq),
        .o_err_full(err_full), .o_out_full(out_full));
    ssr_host u_host (.i_sys_clk(clk), .o_wr(wr), .o_rd(rd), .o_poll(poll), .o_sel(sel), .o_wr_data(wr_data));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic strobe(input int k);
        @(negedge clk);
        cmd[k] = 1'b1;
        @(negedge clk);
        cmd[k] = 1'b0;
    endtask : strobe
    task automatic pulse(input int s, input logic [15:0] v);
        @(negedge clk);
        evt[s] = v;
        @(negedge clk);
        evt[s] = 16'h0000;
    endtask : pulse
    task automatic query(input logic [SEL_W-1:0] s, input logic [15:0] x);
        exp_q.push_back({1'b0, x});
        u_host.put(1'b0, 1'b1, 1'b0, s, 16'h0000);
    endtask : query
    task automatic wr_en(input logic [SEL_W-1:0] s, input logic [15:0] x);
        u_host.put(1'b1, 1'b0, 1'b0, s, x);
    endtask : wr_en
    task automatic do_poll(input logic [7:0] x);
        exp_q.push_back({9'h100, x});
        u_host.put(1'b0, 1'b0, 1'b1, 4'h0, 16'h0000);
    endtask : do_poll
    task automatic stb(input logic [7:0] x);
        tick(3);
        check("status_byte", {8'h00, status_byte}, {8'h00, x});
    endtask : stb

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Answers taken in order of request
    always @(negedge clk) begin
        if (rd_valid === 1'b1 || poll_valid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1_ffff;
            if (e[16] === 1'b1) check("poll_byte", {8'h00, poll_byte}, e[15:0]);
            else check("query_data", rd_data, e[15:0]);
        end
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h119f_a296;
        cmd = 10'h000;
        cond = '{default: 16'h0000};
        evt = '{default: 16'h0000};
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        for (i = 0; i < 13; i++) query(4'(i), 16'h0000);
        stb(8'h00);
        for (i = 0; i < 4; i++) begin
            cond[i] = 16'($random(seed));
            r = 16'($random(seed));
            wr_en(en_sel[i], r);
            query(en_sel[i], r);
            wr_en(ev_sel[i], 16'hffff);
            query(ev_sel[i], 16'h0000);
            if (i > 0) begin
                wr_en(ev_sel[i] - 4'h1, 16'h0000);
                query(ev_sel[i] - 4'h1, cond[i]);
                cond[i] = ~cond[i];
                query(ev_sel[i] - 4'h1, cond[i]);
            end
        end
        r = 16'($random(seed));
        wr_en(SEL_SRE, r);
        query(SEL_SRE, {8'h00, r[7:0]});
        wr_en(SEL_STB, 16'hffff);
        query(SEL_STB, 16'h0000);
        wr_en(SEL_SRE, 16'h00ff);
        for (i = 0; i < 4; i++) begin
            b = 8'h01 << sb_bit[i];
            wr_en(en_sel[i], 16'h8001);
            pulse(i, 16'h0002);
            stb(8'h00);
            pulse(i, 16'h8000);
            stb(b | 8'h40);
            check("service_request", {15'h0000, srq}, 16'h0001);
            do_poll(b | 8'h40);
            do_poll(b);
            check("service_request", {15'h0000, srq}, 16'h0000);
            stb(b | 8'h40);
            query(ev_sel[i], 16'h8002);
            query(ev_sel[i], 16'h0000);
            stb(8'h00);
            wr_en(en_sel[i], 16'h0000);
            query(en_sel[i], 16'h0000);
        end
        wr_en(SEL_SRE, 16'h0040);
        wr_en(en_sel[1], 16'h0001);
        pulse(1, 16'h0001);
        stb(8'h80);
        check("service_request", {15'h0000, srq}, 16'h0000);
        query(SEL_STB, 16'h0080);
        wr_en(SEL_SRE, 16'h0024);
        for (i = 0; i < 4; i++) wr_en(en_sel[i], 16'h00ff);
        strobe(6);
        pulse(0, 16'h0001);
        stb(8'he4);
        strobe(1);
        strobe(4);
        strobe(5);
        stb(8'h64);
        query(en_sel[0], 16'h00ff);
        for (i = 1; i < 4; i++) query(en_sel[i], 16'h0000);
        query(SEL_SRE, 16'h0024);
        strobe(0);
        stb(8'h00);
        query(en_sel[0], 16'h00ff);
        query(SEL_SRE, 16'h0024);
        for (i = 0; i < OUTQ_DEPTH; i++) strobe(8);
        stb(8'h10);
        check("out_full", {15'h0000, out_full}, 16'h0001);
        for (i = 0; i < OUTQ_DEPTH; i++) strobe(9);
        stb(8'h00);
        for (i = 0; i < 4; i++) strobe(6);
        stb(8'h44);
        check("err_full", {15'h0000, err_full}, 16'h0001);
        strobe(7);
        tick(2);
        check("err_full", {15'h0000, err_full}, 16'h0000);
        strobe(2);
        stb(8'h00);
        strobe(6);
        strobe(3);
        stb(8'h00);
        tick(4);
        check("pending", 16'(exp_q.size()), 16'h0000);
        give_verdict();
    end
endmodule : status_summary_service_request_test
